// file: rtl/i2cs_consts.svh
// Constants for the slave-side I2C front end.
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH
`define I2CS_CLK_PERIOD_NS   10
`define I2CS_LONG_HOLD_NS    300
`define I2CS_LONG_HOLD_CYC   ((`I2CS_LONG_HOLD_NS + `I2CS_CLK_PERIOD_NS - 1) / `I2CS_CLK_PERIOD_NS)
`define I2CS_SHORT_HOLD_CYC  3
`define I2CS_HOLD_CNT_W      6
`define I2CS_BIT_CNT_W       4
`define I2CS_ACK_SLOT        4'h8
`define I2CS_TEN_HIGH_TAG    5'h1E
`define I2CS_MODE_7          2'h0
`define I2CS_MODE_10         2'h1
`define I2CS_MODE_7_SP       2'h2
`define I2CS_MODE_10_SP      2'h3
`endif

// file: rtl/i2cs_pkg.sv
// Types for the slave-side I2C front end.
package i2cs_pkg;
   typedef enum logic [4:0] {
      I2CS_IDLE = 5'h01,
      I2CS_ADDR = 5'h02,
      I2CS_LOW  = 5'h04,
      I2CS_RECV = 5'h08,
      I2CS_SEND = 5'h10
   } i2cs_phase_t;

   typedef struct packed {
      logic [2:0]  scl_sync;
      logic [2:0]  sda_sync;
      logic        scl_f;
      logic        sda_f;
      logic        scl_low_seen;
      logic        bus_busy;
      i2cs_phase_t phase;
      logic [3:0]  bit_cnt;
      logic [7:0]  shift;
      logic [7:0]  tx_shift;
      logic        in_ack;
      logic        ack_drive;
      logic        sda_low;
      logic [5:0]  hold_cnt;
      logic        sda_pend;
      logic        pend_val;
      logic        addressed;
      logic        prior_match;
      logic        read_mode;
      logic [7:0]  rx_data;
      logic        rx_valid;
      logic        ack_status;
      logic        ack_time;
      logic        irq_flag;
      logic        collision;
      logic        start_seen;
      logic        stop_seen;
   } i2cs_state_t;
endpackage : i2cs_pkg

// file: rtl/i2cs_slave.sv
// Slave-side I2C front end: bus conditions, address match and acknowledge.
// How it works
// [R1] Long-hold select keeps SDA 300 ns after fall.
// [R2] SDA falling while SCL high is Start.
// [R3] SDA rising while SCL high is Stop.
// [R4] Stop needs one SCL low since Start.
// [R5] Start while we drive SDA low: collision.
// [R6] SDA low while we release high: collision.
// [R7] Restart resets slave like a Start.
// [R8] 10-bit reads need Restart after full match.
// [R9] Prior-match flag held until Stop, mismatch or a matching ten-bit write header.
// [R10] Start/Stop irq enables add interrupts when lacking.
// [R11] Ninth pulse is the active-low acknowledge slot.
// [R12] Sampled acknowledge stored in status bit.
// [R13] Hold enables set: software chooses acknowledge level.
// [R14] Hold enables clear: hardware acknowledges itself.
// [R15] No acknowledge when buffer full or overflow.
// [R16] Ack-time bit after eighth fall, hold modes only.
// [R17] Mode field picks one of four slave modes.
// [R18] Interrupt modes flag Start, Restart and Stop.
// [R19] First byte compared to own address.
// [R20] Seven-bit match ignores the read/write bit.
// [R21] Bus idle only when both lines high.
// [R22] Read request: slave supplies bytes until master NACK, Restart or Stop.
// [R23] Bytes MSB first, SDA sampled on SCL rise.
// [R24] Pins are open drain, never driven high.
// [R25] Interrupt flag stays until software clears it.
// [R26] Bus inputs synchronised and filtered first.
`timescale 1ns/10ps
`include "i2cs_consts.svh"
module i2cs_slave
   import i2cs_pkg::*;
#(
   parameter int unsigned SHORT_HOLD = `I2CS_SHORT_HOLD_CYC,
   parameter int unsigned LONG_HOLD  = `I2CS_LONG_HOLD_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       port_enable_bit,
   input  wire logic [1:0] port_mode_field,
   input  wire logic [9:0] own_address_reg,
   input  wire logic       long_hold_select,
   input  wire logic       start_irq_enable,
   input  wire logic       stop_irq_enable,
   input  wire logic       address_hold_enable,
   input  wire logic       data_hold_enable,
   input  wire logic       ack_data_bit,
   input  wire logic       buffer_full_flag,
   input  wire logic       receive_overflow_flag,
   input  wire logic [7:0] tx_data,
   input  wire logic       irq_clear,
   input  wire logic       rx_taken,
   output logic [7:0]      receive_buffer,
   output logic            rx_valid,
   output logic            ack_status_bit,
   output logic            ack_time_status,
   output logic            port_irq_flag,
   output logic            collision_flag,
   output logic            start_seen,
   output logic            stop_seen,
   output logic            bus_idle,
   output logic            addressed,
   output logic            read_mode,
   output logic            prior_match
);

   if (SHORT_HOLD < 1 || LONG_HOLD < SHORT_HOLD || LONG_HOLD > 63) begin : g_bad_hold
      $error("i2cs_slave: hold counts out of range");
   end

   i2cs_state_t s;
   i2cs_state_t next_s;

   // Seven-bit mode ignores bit 0 of the byte; ten-bit compares the high tag.
   function automatic logic addr_hit(input logic [7:0] b, input logic ten,
                                     input logic [9:0] own);
      if (ten) begin
         addr_hit = (b[7:3] == `I2CS_TEN_HIGH_TAG) && (b[2:1] == own[9:8]);
      end else begin
         addr_hit = (b[7:1] == own[6:0]); // [R20]
      end
   endfunction : addr_hit

   logic ten_mode;
   logic sp_mode;
   logic hold_mode;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic [7:0] byte_in;

   assign ten_mode  = (port_mode_field == `I2CS_MODE_10) ||
                      (port_mode_field == `I2CS_MODE_10_SP); // [R17]
   assign sp_mode   = (port_mode_field == `I2CS_MODE_7_SP) ||
                      (port_mode_field == `I2CS_MODE_10_SP);
   assign hold_mode = address_hold_enable | data_hold_enable;
   // Filtered levels: a change is accepted only when the last two sync stages agree.
   assign scl_rise  = !s.scl_f && s.scl_sync[2] && s.scl_sync[1]; // [R26]
   assign scl_fall  = s.scl_f && !s.scl_sync[2] && !s.scl_sync[1];
   assign start_ev  = s.scl_f && s.scl_sync[2] && s.sda_f &&
                      !s.sda_sync[2] && !s.sda_sync[1]; // [R2]
   assign stop_ev   = s.scl_f && s.scl_sync[2] && !s.sda_f &&
                      s.sda_sync[2] && s.sda_sync[1] && s.scl_low_seen; // [R3] [R4]
   assign byte_in   = {s.shift[6:0], s.sda_f};

   always_comb begin
      next_s = s;
      next_s.scl_sync = {s.scl_sync[1:0], scl_in};
      next_s.sda_sync = {s.sda_sync[1:0], sda_in};
      if (s.scl_sync[2] == s.scl_sync[1]) begin
         next_s.scl_f = s.scl_sync[2];
      end
      if (s.sda_sync[2] == s.sda_sync[1]) begin
         next_s.sda_f = s.sda_sync[2];
      end
      // Any set further down overrides this clear, so a new event is never lost.
      if (irq_clear) begin
         next_s.irq_flag = 1'b0; // [R25]
      end
      if (rx_taken) begin
         next_s.rx_valid = 1'b0;
      end
      next_s.start_seen = 1'b0;
      next_s.stop_seen  = 1'b0;
      if (scl_fall) begin
         next_s.scl_low_seen = 1'b1;
      end

      // Delayed SDA update after an SCL fall keeps the hold time.
      if (s.sda_pend) begin
         if (s.hold_cnt <= 6'h01) begin
            next_s.sda_low  = s.pend_val;
            next_s.sda_pend = 1'b0;
         end else begin
            next_s.hold_cnt = s.hold_cnt - 6'h01;
         end
      end

      // A released SDA read back low while we send means another driver won.
      if (s.phase == I2CS_SEND && !s.sda_low && !s.sda_pend && !s.in_ack &&
          s.scl_f && !s.sda_f) begin
         next_s.collision = 1'b1; // [R6]
         next_s.phase     = I2CS_IDLE;
      end

      if (scl_rise && s.phase != I2CS_IDLE) begin
         if (s.in_ack) begin
            if (s.read_mode && !s.ack_drive) begin
               next_s.ack_status = s.sda_f; // [R12]
            end
         end else begin
            next_s.shift   = byte_in; // [R23]
            next_s.bit_cnt = s.bit_cnt + 4'h1;
         end
      end

      if (scl_fall && s.phase != I2CS_IDLE) begin
         next_s.sda_pend = 1'b1;
         next_s.hold_cnt = long_hold_select ? 6'(LONG_HOLD) : 6'(SHORT_HOLD); // [R1]
         next_s.pend_val = 1'b0;
         if (s.in_ack) begin
            // End of the acknowledge slot.
            next_s.in_ack    = 1'b0;
            next_s.ack_time  = 1'b0;
            next_s.bit_cnt   = 4'h0;
            next_s.ack_drive = 1'b0;
            if (s.read_mode && s.ack_status && !s.ack_drive) begin
               next_s.phase = I2CS_IDLE;
            end
            if (s.phase == I2CS_SEND && next_s.phase != I2CS_IDLE) begin
               next_s.tx_shift = tx_data;
               next_s.pend_val = !tx_data[7];
            end else if (s.phase == I2CS_ADDR && s.read_mode) begin
               next_s.phase    = I2CS_SEND; // [R22]
               next_s.tx_shift = tx_data;
               next_s.pend_val = !tx_data[7];
            end
         end else if (s.bit_cnt == `I2CS_ACK_SLOT) begin
            // Eighth fall: a full byte has been taken in.
            next_s.in_ack = 1'b1; // [R11]
            if (s.phase == I2CS_SEND) begin
               next_s.pend_val = 1'b0;
            end else if (s.phase == I2CS_ADDR || s.phase == I2CS_LOW) begin
               if (s.phase == I2CS_LOW) begin
                  if (s.shift == own_address_reg[7:0]) begin
                     next_s.addressed   = 1'b1;
                     next_s.prior_match = 1'b1; // [R9]
                     next_s.phase       = I2CS_RECV;
                  end else begin
                     next_s.phase = I2CS_IDLE;
                  end
               end else if (addr_hit(s.shift, ten_mode, own_address_reg)) begin // [R19]
                  if (ten_mode && !s.shift[0]) begin
                     next_s.prior_match = 1'b0; // [R9]
                     next_s.phase       = I2CS_LOW;
                  end else if (ten_mode && !s.prior_match) begin
                     next_s.phase = I2CS_IDLE; // [R8]
                  end else begin
                     next_s.addressed = 1'b1;
                     next_s.read_mode = s.shift[0];
                     next_s.phase     = s.shift[0] ? I2CS_ADDR : I2CS_RECV;
                  end
               end else begin
                  next_s.prior_match = ten_mode ? 1'b0 : s.prior_match; // [R9]
                  next_s.phase       = I2CS_IDLE;
               end
               if (next_s.phase != I2CS_IDLE) begin
                  next_s.rx_data  = s.shift;
                  next_s.rx_valid = 1'b1;
                  next_s.irq_flag = 1'b1;
               end
            end else begin
               next_s.rx_data  = s.shift;
               next_s.rx_valid = 1'b1;
               next_s.irq_flag = 1'b1;
            end
            if (s.phase != I2CS_SEND && next_s.phase != I2CS_IDLE) begin
               if (buffer_full_flag || receive_overflow_flag) begin
                  next_s.pend_val = 1'b0; // [R15]
               end else if (hold_mode) begin
                  next_s.pend_val = !ack_data_bit; // [R13]
               end else begin
                  next_s.pend_val = 1'b1; // [R14]
               end
               next_s.ack_drive = next_s.pend_val;
               next_s.ack_time  = hold_mode; // [R16]
            end
         end else if (s.phase == I2CS_SEND) begin
            next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
            next_s.pend_val = !s.tx_shift[6]; // [R23]
         end
      end

      if (start_ev) begin
         // Start or Restart: the next byte is an address again.
         next_s.bus_busy     = 1'b1; // [R2]
         next_s.scl_low_seen = 1'b0;
         next_s.phase        = I2CS_ADDR; // [R7]
         next_s.bit_cnt      = 4'h0;
         next_s.in_ack       = 1'b0;
         next_s.ack_time     = 1'b0;
         next_s.addressed    = 1'b0;
         next_s.read_mode    = 1'b0;
         next_s.sda_low      = 1'b0;
         next_s.sda_pend     = 1'b0;
         next_s.start_seen   = 1'b1;
         if (s.sda_low) begin
            next_s.collision = 1'b1; // [R5]
         end
         if (sp_mode || start_irq_enable) begin
            next_s.irq_flag = 1'b1; // [R18] [R10]
         end
      end else if (stop_ev) begin
         next_s.bus_busy    = 1'b0;
         next_s.phase       = I2CS_IDLE;
         next_s.addressed   = 1'b0;
         next_s.read_mode   = 1'b0;
         next_s.in_ack      = 1'b0;
         next_s.ack_time    = 1'b0;
         next_s.sda_low     = 1'b0;
         next_s.sda_pend    = 1'b0;
         next_s.prior_match = 1'b0; // [R9]
         next_s.stop_seen   = 1'b1;
         if (sp_mode || stop_irq_enable) begin
            next_s.irq_flag = 1'b1; // [R18] [R10]
         end
      end

      if (!port_enable_bit) begin
         next_s.phase    = I2CS_IDLE;
         next_s.sda_low  = 1'b0;
         next_s.sda_pend = 1'b0;
         next_s.bus_busy = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s          <= '0;
         s.scl_sync <= 3'h7;
         s.sda_sync <= 3'h7;
         s.scl_f    <= 1'b1;
         s.sda_f    <= 1'b1;
         s.phase    <= I2CS_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign scl_out         = 1'b0; // [R24]
   assign scl_oe_n        = 1'b1;
   assign sda_out         = 1'b0;
   assign sda_oe_n        = !(s.sda_low && port_enable_bit); // [R24]
   assign receive_buffer  = s.rx_data;
   assign rx_valid        = s.rx_valid;
   assign ack_status_bit  = s.ack_status;
   assign ack_time_status = s.ack_time;
   assign port_irq_flag   = s.irq_flag;
   assign collision_flag  = s.collision;
   assign start_seen      = s.start_seen;
   assign stop_seen       = s.stop_seen;
   assign bus_idle        = !s.bus_busy && s.scl_f && s.sda_f; // [R21]
   assign addressed       = s.addressed;
   assign read_mode       = s.read_mode;
   assign prior_match     = s.prior_match;

   property p_stop_clears;
      @(posedge clk) disable iff (!rst_n) stop_ev |=> !s.addressed && !s.prior_match;
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("stop left state"); // [R9]

   property p_start_addr;
      @(posedge clk) disable iff (!rst_n)
         start_ev && port_enable_bit |=> s.phase == I2CS_ADDR && s.bit_cnt == 4'h0;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start not to address"); // [R7]

   property p_sp_irq;
      @(posedge clk) disable iff (!rst_n)
         (start_ev || stop_ev) && sp_mode && !irq_clear |=> s.irq_flag;
   endproperty
   a_sp_irq: assert property (p_sp_irq) else $error("no irq on condition"); // [R18]

   property p_irq_sticky;
      @(posedge clk) disable iff (!rst_n) s.irq_flag && !irq_clear |=> s.irq_flag;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag dropped"); // [R25]

   property p_no_stop_without_low;
      @(posedge clk) disable iff (!rst_n) start_ev |=> !s.scl_low_seen && !s.stop_seen;
   endproperty
   a_no_stop_without_low: assert property (p_no_stop_without_low) else $error("early stop"); // [R4]

   property p_idle_lines;
      @(posedge clk) disable iff (!rst_n)
         start_ev && port_enable_bit |=> s.bus_busy && !bus_idle;
   endproperty
   a_idle_lines: assert property (p_idle_lines) else $error("idle with low line"); // [R21]

   property p_ack_time_hold;
      @(posedge clk) disable iff (!rst_n) s.ack_time |-> hold_mode && s.in_ack;
   endproperty
   a_ack_time_hold: assert property (p_ack_time_hold) else $error("ack time bad"); // [R16]

   property p_nack_full;
      @(posedge clk) disable iff (!rst_n)
         scl_fall && s.bit_cnt == `I2CS_ACK_SLOT && !s.in_ack && s.phase != I2CS_SEND &&
         (buffer_full_flag || receive_overflow_flag) |=> !s.ack_drive;
   endproperty
   a_nack_full: assert property (p_nack_full) else $error("ack while full"); // [R15]

endmodule : i2cs_slave

// file: verif/i2cs_master_model.sv
// Behavioural I2C bus master that drives SCL and SDA towards the slave.
`timescale 1ns/10ps
module i2cs_master_model (
   input  wire logic clk,
   input  wire logic sda_bus,
   output logic      scl_drv,
   output logic      sda_drv
);
   // The low phase must outlast the slave's input synchroniser plus its SDA hold delay,
   // otherwise the acknowledge edge would land while SCL is high and look like a Start.
   int   t_low  = 12;
   int   t_high = 8;
   logic jam    = 1'b0;

   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic bit_cyc(input logic b, output logic s);
      sda_drv <= b;
      tick(t_low / 2);
      scl_drv <= 1'b1;
      tick(t_high - 1);
      @(negedge clk);
      s = sda_bus;
      @(posedge clk);
      scl_drv <= 1'b0;
      tick(t_low / 2);
   endtask : bit_cyc

   task automatic start_cond();
      sda_drv <= 1'b0;
      tick(t_high);
      scl_drv <= 1'b0;
      tick(t_low / 2);
   endtask : start_cond

   task automatic restart_cond();
      sda_drv <= 1'b1;
      tick(t_low / 2);
      scl_drv <= 1'b1;
      tick(t_high);
      start_cond();
   endtask : restart_cond

   task automatic stop_cond();
      sda_drv <= 1'b0;
      tick(t_low / 2);
      scl_drv <= 1'b1;
      tick(t_high);
      sda_drv <= 1'b1;
      tick(t_high);
   endtask : stop_cond

   task automatic glitch();
      sda_drv <= 1'b0;
      tick(t_high);
      sda_drv <= 1'b1;
      tick(t_high);
   endtask : glitch

   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(b[i], s);
      bit_cyc(1'b1, ack);
   endtask : write_byte

   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(!jam, s);
         d[i] = s;
      end
      bit_cyc(ack, s);
   endtask : read_byte
endmodule : i2cs_master_model

// file: verif/i2cs_slave_tb_top.sv
// Self-checking bench for the slave-side I2C front end.
`timescale 1ns/10ps
`include "i2cs_consts.svh"
module i2c_slave_bus_conditions_ack_tb_top;
   logic       clk, rst_n, scl_in, sda_in, scl_out, scl_oe_n, sda_out, sda_oe_n, m_scl, m_sda;
   logic       port_enable_bit, long_hold_select, start_irq_enable, stop_irq_enable;
   logic       address_hold_enable, data_hold_enable, ack_data_bit, buffer_full_flag;
   logic       receive_overflow_flag, irq_clear, rx_taken, rx_valid, ack_status_bit;
   logic       ack_time_status, port_irq_flag, collision_flag, start_seen, stop_seen;
   logic       bus_idle, addressed, read_mode, prior_match, scl_q, oe_q, a;
   logic [1:0] port_mode_field;
   logic [9:0] own_address_reg;
   logic [7:0] tx_data, receive_buffer, d;
   int         checks, n_mismatch, n_start, n_stop, n_tim, fall_cnt, rel_gap, s0, p0, t0;

   assign scl_in = m_scl & (scl_oe_n | scl_out);
   assign sda_in = m_sda & (sda_oe_n | sda_out);

   i2cs_slave u_dut (.clk, .rst_n, .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n,
      .port_enable_bit, .port_mode_field, .own_address_reg, .long_hold_select,
      .start_irq_enable, .stop_irq_enable, .address_hold_enable, .data_hold_enable,
      .ack_data_bit, .buffer_full_flag, .receive_overflow_flag, .tx_data, .irq_clear,
      .rx_taken, .receive_buffer, .rx_valid, .ack_status_bit, .ack_time_status,
      .port_irq_flag, .collision_flag, .start_seen, .stop_seen, .bus_idle, .addressed,
      .read_mode, .prior_match);

   i2cs_master_model u_mst (.clk(clk), .sda_bus(sda_in), .scl_drv(m_scl), .sda_drv(m_sda));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Pulses are counted here so that no scenario has to catch them in their single cycle.
   always @(posedge clk) begin
      scl_q <= scl_in;
      oe_q  <= sda_oe_n;
      fall_cnt <= (scl_q & ~scl_in) ? 0 : fall_cnt + 1;
      if (sda_oe_n & ~oe_q) rel_gap <= fall_cnt;
      if (start_seen) n_start <= n_start + 1;
      if (stop_seen) n_stop <= n_stop + 1;
      if (ack_time_status) n_tim <= n_tim + 1;
   end

   task automatic chk1(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8

   task automatic print_verdict();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic clr();
      irq_clear <= 1'b1;
      rx_taken  <= 1'b1;
      @(posedge clk);
      irq_clear <= 1'b0;
      rx_taken  <= 1'b0;
      @(posedge clk);
   endtask : clr

   task automatic sc_glitch();
      s0 = n_start;
      p0 = n_stop;
      u_mst.glitch();
      chk1("start count", 1'b1, (n_start - s0) == 1);
      chk1("stop count", 1'b0, (n_stop - p0) != 0);
   endtask : sc_glitch

   task automatic sc_write7();
      t0 = n_tim;
      p0 = n_stop;
      u_mst.start_cond();
      u_mst.write_byte(8'h4A, a);
      chk1("address ack", 1'b0, a);
      chk8("receive buffer", 8'h4A, receive_buffer);
      chk1("rx valid", 1'b1, rx_valid);
      chk1("read mode", 1'b0, read_mode);
      chk1("addressed", 1'b1, addressed);
      repeat (20) @(posedge clk);
      chk1("irq held", 1'b1, port_irq_flag);
      clr();
      chk1("irq cleared", 1'b0, port_irq_flag);
      u_mst.write_byte(8'h3C, a);
      chk1("data ack", 1'b0, a);
      chk8("data byte", 8'h3C, receive_buffer);
      chk1("short hold", 1'b1, rel_gap < 30);
      chk1("ack time idle", 1'b1, n_tim == t0);
      chk1("sda level", 1'b0, sda_out);
      chk1("scl level", 1'b0, scl_out);
      chk1("scl released", 1'b1, scl_oe_n);
      u_mst.stop_cond();
      chk1("stop count", 1'b1, (n_stop - p0) == 1);
      chk1("bus idle", 1'b1, bus_idle);
      chk1("addressed after stop", 1'b0, addressed);
      clr();
   endtask : sc_write7

   task automatic sc_read7();
      tx_data <= 8'hA6;
      u_mst.start_cond();
      u_mst.write_byte(8'h4B, a);
      chk1("read address ack", 1'b0, a);
      chk1("read mode", 1'b1, read_mode);
      tx_data <= 8'h59;
      u_mst.read_byte(1'b0, d);
      chk8("first read byte", 8'hA6, d);
      chk1("ack status", 1'b0, ack_status_bit);
      u_mst.read_byte(1'b1, d);
      chk8("second read byte", 8'h59, d);
      chk1("nack status", 1'b1, ack_status_bit);
      u_mst.stop_cond();
      clr();
   endtask : sc_read7

   task automatic sc_miss();
      u_mst.start_cond();
      u_mst.write_byte(8'h4C, a);
      chk1("mismatch ack", 1'b1, a);
      chk1("mismatch irq", 1'b0, port_irq_flag);
      chk1("mismatch rx valid", 1'b0, rx_valid);
      u_mst.stop_cond();
      clr();
   endtask : sc_miss

   task automatic sc_full();
      for (int i = 0; i < 3; i++) begin
         buffer_full_flag      <= (i == 0);
         receive_overflow_flag <= (i == 1);
         port_enable_bit       <= (i != 2);
         u_mst.start_cond();
         u_mst.write_byte(8'h4A, a);
         chk1("overflow ack", 1'b1, a);
         u_mst.stop_cond();
         clr();
      end
      buffer_full_flag      <= 1'b0;
      receive_overflow_flag <= 1'b0;
      port_enable_bit       <= 1'b1;
   endtask : sc_full

   task automatic sc_hold();
      address_hold_enable <= 1'b1;
      data_hold_enable    <= 1'b1;
      ack_data_bit        <= 1'b1;
      t0 = n_tim;
      u_mst.start_cond();
      u_mst.write_byte(8'h4A, a);
      chk1("chosen nack", 1'b1, a);
      chk1("ack time set", 1'b1, n_tim != t0);
      ack_data_bit <= 1'b0;
      u_mst.restart_cond();
      u_mst.write_byte(8'h4A, a);
      chk1("chosen ack", 1'b0, a);
      u_mst.stop_cond();
      clr();
      address_hold_enable <= 1'b0;
      data_hold_enable    <= 1'b0;
   endtask : sc_hold

   task automatic sc_modes();
      for (int m = 0; m < 4; m++) begin
         for (int e = 0; e < 2; e++) begin
            port_mode_field  <= m[1:0];
            start_irq_enable <= e[0];
            stop_irq_enable  <= e[0];
            @(posedge clk);
            u_mst.start_cond();
            chk1("start irq", m[1] | e[0], port_irq_flag);
            clr();
            u_mst.stop_cond();
            chk1("stop irq", m[1] | e[0], port_irq_flag);
            clr();
         end
      end
      port_mode_field  <= `I2CS_MODE_7;
      start_irq_enable <= 1'b0;
      stop_irq_enable  <= 1'b0;
   endtask : sc_modes

   task automatic sc_ten();
      port_mode_field <= `I2CS_MODE_10;
      tx_data         <= 8'hC3;
      u_mst.start_cond();
      u_mst.write_byte(8'hF4, a);
      chk1("high byte ack", 1'b0, a);
      u_mst.write_byte(8'hA5, a);
      chk1("low byte ack", 1'b0, a);
      chk1("prior match set", 1'b1, prior_match);
      u_mst.restart_cond();
      u_mst.write_byte(8'hF5, a);
      chk1("read high ack", 1'b0, a);
      chk1("ten bit read", 1'b1, read_mode);
      u_mst.read_byte(1'b1, d);
      chk8("ten bit data", 8'hC3, d);
      u_mst.restart_cond();
      u_mst.write_byte(8'hF6, a);
      chk1("wrong high nack", 1'b1, a);
      chk1("prior match lost", 1'b0, prior_match);
      u_mst.stop_cond();
      clr();
      port_mode_field <= `I2CS_MODE_7;
   endtask : sc_ten

   task automatic sc_long();
      long_hold_select <= 1'b1;
      u_mst.t_low = 40;
      u_mst.start_cond();
      u_mst.write_byte(8'h4A, a);
      u_mst.write_byte(8'h3C, a);
      chk1("long hold", 1'b1, rel_gap >= 30);
      u_mst.stop_cond();
      clr();
      u_mst.t_low = 12;
      long_hold_select <= 1'b0;
   endtask : sc_long

   task automatic sc_coll();
      tx_data <= 8'hFF;
      u_mst.start_cond();
      u_mst.write_byte(8'h4B, a);
      u_mst.jam = 1'b1;
      u_mst.read_byte(1'b1, d);
      u_mst.jam = 1'b0;
      chk1("collision", 1'b1, collision_flag);
      u_mst.stop_cond();
   endtask : sc_coll

   initial begin
      rst_n = 1'b0;
      port_enable_bit = 1'b1;
      port_mode_field = `I2CS_MODE_7;
      own_address_reg = 10'h2A5;
      {long_hold_select, start_irq_enable, stop_irq_enable, address_hold_enable} = 4'h0;
      {data_hold_enable, ack_data_bit, buffer_full_flag, receive_overflow_flag} = 4'h0;
      {irq_clear, rx_taken, scl_q, oe_q} = 4'hF;
      tx_data = 8'h00;
      {checks, n_mismatch, n_start, n_stop, n_tim, fall_cnt, rel_gap} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      irq_clear <= 1'b0;
      rx_taken  <= 1'b0;
      repeat (4) @(posedge clk);
      chk1("reset sda release", 1'b1, sda_oe_n);
      chk1("reset idle", 1'b1, bus_idle);
      sc_glitch();
      sc_write7();
      sc_read7();
      sc_miss();
      sc_full();
      sc_hold();
      sc_modes();
      sc_ten();
      sc_long();
      sc_coll();
      print_verdict();
   end

   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
endmodule : i2c_slave_bus_conditions_ack_tb_top
